// [hdl/crf_defs.svh]
// constants for the cpu register file
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_SLOT_FP    4'h0
`define CRF_SLOT_HI    4'h1
`define CRF_SLOT_SP    4'hd
`define CRF_SLOT_ST    4'he
`define CRF_SLOT_ZERO  4'hf
`define CRF_ZERO_WORD  16'h0000
`define CRF_ST_C       15
`define CRF_ST_N       14
`define CRF_ST_Z       13
`define CRF_ST_V       12
`define CRF_ST_KEEP    16'hf007
`define CRF_MASK_ALL   3'h7
`define CRF_STACK_STEP 16'h0002
`define CRF_TRAP_BASE  17'h08000
`define CRF_PC_RESET   16'h0000
`endif

// [hdl/crf_pkg.sv]
// types for the cpu register file
package crf_pkg;
	typedef enum logic [1:0] {
		CRF_SZ_BIT  = 2'b00,
		CRF_SZ_BYTE = 2'b01,
		CRF_SZ_WORD = 2'b10,
		CRF_SZ_LONG = 2'b11
	} crf_size_e;

	typedef enum logic [1:0] {
		CRF_ALU_PASS = 2'b00,
		CRF_ALU_ADD  = 2'b01,
		CRF_ALU_SUB  = 2'b10
	} crf_alu_e;

	typedef enum logic [2:0] {
		CRF_OP_NONE   = 3'b000,
		CRF_OP_CALL   = 3'b001,
		CRF_OP_RTS    = 3'b010,
		CRF_OP_LINK   = 3'b011,
		CRF_OP_UNLINK = 3'b100,
		CRF_OP_RETURN_AND_RELEASE   = 3'b101,
		CRF_OP_TRAP   = 3'b110,
		CRF_OP_RTI    = 3'b111
	} crf_stack_op_e;

	typedef struct packed {
		logic        we;
		logic [3:0]  addr;
		crf_size_e   size;
		logic [3:0]  bit_idx;
		logic [15:0] data;
	} crf_wr_s;

	typedef struct packed {
		logic        upd;
		logic        wb;
		logic [3:0]  dest;
		crf_size_e   size;
		crf_alu_e    kind;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] result;
		logic        c_in;
		logic        v_in;
		logic        round;
	} crf_alu_s;

	typedef struct packed {
		crf_stack_op_e op;
		logic [15:0]   arg;
		logic [7:0]    vec;
	} crf_stk_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [16:0] addr;
		logic [15:0] wdata;
	} crf_mem_s;
endpackage : crf_pkg

// [hdl/crf_flags.sv]
// condition flag and long result evaluation
`timescale 1ns/1ns
module crf_flags (
	input  crf_pkg::crf_alu_s req,
	output logic [31:0]       res,
	output logic              flag_c,
	output logic              flag_n,
	output logic              flag_z,
	output logic              flag_v
);
	import crf_pkg::*;

	logic [32:0] sum;
	logic [31:0] b_eff;
	logic [31:0] raw;
	logic        a_msb;
	logic        b_msb;
	logic        r_msb;
	logic        cy;

	always_comb
	begin
		b_eff = (req.kind == CRF_ALU_SUB) ? ~req.b : req.b;
		sum = {1'b0, req.a} + {1'b0, b_eff} + {32'h0, req.kind == CRF_ALU_SUB};
		raw = (req.kind == CRF_ALU_PASS) ? req.result : sum[31:0];
		a_msb = 1'b0;
		b_msb = 1'b0;
		r_msb = 1'b0;
		cy = req.c_in;
		flag_z = 1'b0;
		unique case (req.size)
			CRF_SZ_BIT:
			begin
				cy = req.kind == CRF_ALU_PASS ? raw[0] : req.c_in;
				flag_z = ~raw[0];
			end
			CRF_SZ_BYTE:
			begin
				a_msb = req.a[7];
				b_msb = b_eff[7];
				r_msb = raw[7];
				cy = req.a[8] ^ b_eff[8] ^ sum[8];
				flag_z = raw[7:0] == 8'h00;
			end
			CRF_SZ_WORD:
			begin
				a_msb = req.a[15];
				b_msb = b_eff[15];
				r_msb = raw[15];
				cy = req.a[16] ^ b_eff[16] ^ sum[16];
				flag_z = raw[15:0] == 16'h0000;
			end
			CRF_SZ_LONG:
			begin
				a_msb = req.a[31];
				b_msb = b_eff[31];
				r_msb = raw[31];
				cy = sum[32];
				flag_z = raw == 32'h0;
			end
		endcase
		if (req.kind == CRF_ALU_PASS)
		begin
			flag_c = (req.size == CRF_SZ_BIT) ? cy : req.c_in;
			flag_v = req.v_in;
		end
		else
		begin
			flag_c = (req.kind == CRF_ALU_SUB) ? ~cy : cy;
			flag_v = (a_msb == b_msb) && (r_msb != a_msb);
		end
		flag_n = r_msb;
		res = raw;
		if (req.round && flag_n && flag_c)
		begin
			res = raw + 32'h1;
		end
	end
endmodule : crf_flags

// [hdl/crf_top.sv]
// cpu register file, program counter and stack sequencer
// Overview of operation
// - sixteen internal slots, not memory mapped
// - slot fifteen reads zero, writes dropped
// - reset leaves slot contents untouched
// - fetch address is pc with bit zero low
// - separate 16-bit word-address program counter
// - slots two to twelve: bit, byte, word
// - flags judged at 8, 16, 32 bits
// - zero flag set on all-zero result
// - negative flag from result top bit
// - carry: unsigned carry, shift target, bit accumulator
// - overflow set on signed overflow
// - status holds three-bit interrupt mask level
// - reserved status bits hold no data
// - slot one takes long high word, remainder
// - rounding shift adds one when n and c
// - link: push fp, fp=sp, sp+=space
// - unlink: sp=fp, pop fp
// - release return: sp=fp, pop fp, pc, subtract
// - trap: push status, pc, load vector, mask seven
// - interrupt return pops pc and status
// - call pushes return address, return pops it
// - index slot fifteen gives displacement only
// - sp plus two after push, minus before pop
// - odd sp stack access pulses illegal_access, op abandoned
`timescale 1ns/1ns
`include "crf_defs.svh"
module crf_top (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [3:0]   rd_a_addr,
	input  wire logic [3:0]   rd_b_addr,
	input  crf_pkg::crf_wr_s  wr,
	input  crf_pkg::crf_alu_s alu,
	input  crf_pkg::crf_stk_s stk,
	input  wire logic         pc_load,
	input  wire logic [15:0]  pc_target,
	input  wire logic         pc_advance,
	input  wire logic [3:0]   ea_idx,
	input  wire logic [15:0]  ea_disp,
	input  wire logic [15:0]  mem_rdata,
	output logic [15:0]       rd_a_data,
	output logic [15:0]       rd_b_data,
	output logic [15:0]       status_word,
	output logic [15:0]       pc,
	output logic [16:0]       fetch_addr,
	output logic [15:0]       ea,
	output crf_pkg::crf_mem_s mem,
	output logic              busy,
	output logic              illegal_access
);
	import crf_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_PUSH1 = 4'h1,
		ST_PUSH2 = 4'h2,
		ST_POP1  = 4'h3,
		ST_POPQ1 = 4'h4,
		ST_POPD1 = 4'h5,
		ST_POP2  = 4'h6,
		ST_POPQ2 = 4'h7,
		ST_POPD2 = 4'h8,
		ST_VEC   = 4'h9,
		ST_VECQ  = 4'ha,
		ST_VECD  = 4'hb,
		ST_ADJ   = 4'hc
	} crf_state_e;

	logic [15:0]   slot [0:14];
	logic [15:0]   wval [0:14];
	logic          wen  [0:14];
	crf_state_e    state;
	crf_state_e    next_state;
	crf_stack_op_e op_r;
	logic [15:0]   arg_r;
	logic [7:0]    vec_r;
	crf_mem_s      next_mem;
	logic          next_illegal;
	logic          fsm_sp_we;
	logic          fsm_fp_we;
	logic          fsm_st_we;
	logic          fsm_pc_we;
	logic [15:0]   fsm_sp_val;
	logic [15:0]   fsm_fp_val;
	logic [15:0]   fsm_st_val;
	logic [15:0]   fsm_pc_val;
	logic [15:0]   next_pc;
	logic [31:0]   alu_res;
	logic          f_c;
	logic          f_n;
	logic          f_z;
	logic          f_v;
	logic [15:0]   sp_r;
	logic [15:0]   st_r;

	function automatic logic [15:0] rd_slot(input logic [3:0] idx);
		rd_slot = (idx == `CRF_SLOT_ZERO) ? `CRF_ZERO_WORD : slot[idx];
	endfunction : rd_slot

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input crf_size_e sz, input logic [3:0] bi);
		merge = d;
		if (sz == CRF_SZ_BIT)
		begin
			merge = old;
			merge[bi] = d[0];
		end
		else if (sz == CRF_SZ_BYTE)
		begin
			merge = {old[15:8], d[7:0]};
		end
	endfunction : merge

	crf_flags u_flags (
		.req    (alu),
		.res    (alu_res),
		.flag_c (f_c),
		.flag_n (f_n),
		.flag_z (f_z),
		.flag_v (f_v)
	);

	assign sp_r = slot[`CRF_SLOT_SP];
	assign st_r = slot[`CRF_SLOT_ST];

	// one write path per slot; slot fifteen has no storage
	for (genvar g = 0; g < 15; g++)
	begin : g_slot
		always_comb
		begin
			wen[g] = 1'b1;
			wval[g] = slot[g];
			if (g == 0 && fsm_fp_we)
				wval[g] = fsm_fp_val;
			else if (g == 13 && fsm_sp_we)
				wval[g] = fsm_sp_val;
			else if (g == 14 && fsm_st_we)
				wval[g] = fsm_st_val;
			else if (alu.upd && alu.wb && alu.dest == 4'(g))
				wval[g] = merge(slot[g], alu_res[15:0], alu.size, 4'h0);
			else if (g == 1 && alu.upd && alu.wb && alu.size == CRF_SZ_LONG)
				wval[g] = alu_res[31:16];
			else if (wr.we && wr.addr == 4'(g))
				wval[g] = merge(slot[g], wr.data, wr.size, wr.bit_idx);
			else if (g == 14 && alu.upd)
			begin
				wval[g][`CRF_ST_C] = f_c;
				wval[g][`CRF_ST_N] = f_n;
				wval[g][`CRF_ST_Z] = f_z;
				wval[g][`CRF_ST_V] = f_v;
			end
			else
				wen[g] = 1'b0;
			if (g == 14)
				wval[g] = wval[g] & `CRF_ST_KEEP;
		end

		// no reset on the storage itself
		always_ff @(posedge clk_sys)
		begin
			if (wen[g])
				slot[g] <= wval[g];
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rd_a_data <= `CRF_ZERO_WORD;
			rd_b_data <= `CRF_ZERO_WORD;
			status_word <= `CRF_ZERO_WORD;
			ea <= `CRF_ZERO_WORD;
		end
		else
		begin
			rd_a_data <= rd_slot(rd_a_addr);
			rd_b_data <= rd_slot(rd_b_addr);
			status_word <= st_r;
			ea <= ea_disp + rd_slot(ea_idx);
		end
	end

	always_comb
	begin
		next_pc = pc;
		if (fsm_pc_we)
			next_pc = fsm_pc_val;
		else if (pc_load)
			next_pc = pc_target;
		else if (pc_advance)
			next_pc = pc + 16'h0001;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pc <= `CRF_PC_RESET;
			fetch_addr <= {`CRF_PC_RESET, 1'b0};
		end
		else
		begin
			pc <= next_pc;
			fetch_addr <= {next_pc, 1'b0};
		end
	end

	// stack sequencer: one memory word per request, data the cycle after
	always_comb
	begin
		next_state = state;
		next_mem = '0;
		next_illegal = 1'b0;
		fsm_sp_we = 1'b0;
		fsm_fp_we = 1'b0;
		fsm_st_we = 1'b0;
		fsm_pc_we = 1'b0;
		fsm_sp_val = sp_r + `CRF_STACK_STEP;
		fsm_fp_val = mem_rdata;
		fsm_st_val = mem_rdata;
		fsm_pc_val = mem_rdata;
		unique case (state)
			ST_IDLE:
			begin
				unique case (stk.op)
					CRF_OP_NONE:
						next_state = ST_IDLE;
					CRF_OP_CALL, CRF_OP_LINK, CRF_OP_TRAP:
						next_state = ST_PUSH1;
					CRF_OP_RTS, CRF_OP_RTI:
						next_state = ST_POP1;
					CRF_OP_UNLINK, CRF_OP_RETURN_AND_RELEASE:
					begin
						fsm_sp_we = 1'b1;
						fsm_sp_val = slot[`CRF_SLOT_FP];
						next_state = ST_POP1;
					end
				endcase
			end
			ST_PUSH1, ST_PUSH2:
			begin
				if (sp_r[0])
				begin
					next_illegal = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					next_mem = {1'b1, 1'b1, 1'b0, sp_r, pc};
					if (state == ST_PUSH1 && op_r == CRF_OP_TRAP)
						next_mem.wdata = st_r;
					else if (op_r == CRF_OP_LINK)
						next_mem.wdata = slot[`CRF_SLOT_FP];
					fsm_sp_we = 1'b1;
					next_state = ST_IDLE;
					if (op_r == CRF_OP_TRAP)
						next_state = (state == ST_PUSH1) ? ST_PUSH2 : ST_VEC;
					else if (op_r == CRF_OP_CALL)
					begin
						fsm_pc_we = 1'b1;
						fsm_pc_val = arg_r;
					end
					else
					begin
						fsm_fp_we = 1'b1;
						fsm_fp_val = fsm_sp_val;
						next_state = ST_ADJ;
					end
				end
			end
			ST_POP1, ST_POP2:
			begin
				if (sp_r[0])
				begin
					next_illegal = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					fsm_sp_we = 1'b1;
					fsm_sp_val = sp_r - `CRF_STACK_STEP;
					next_mem = {1'b1, 1'b0, 1'b0, fsm_sp_val, `CRF_ZERO_WORD};
					next_state = (state == ST_POP1) ? ST_POPQ1 : ST_POPQ2;
				end
			end
			ST_POPQ1:
				next_state = ST_POPD1;
			ST_POPQ2:
				next_state = ST_POPD2;
			ST_VECQ:
				next_state = ST_VECD;
			ST_POPD1:
			begin
				next_state = ST_IDLE;
				if (op_r == CRF_OP_RTS || op_r == CRF_OP_RTI)
					fsm_pc_we = 1'b1;
				else
					fsm_fp_we = 1'b1;
				if (op_r == CRF_OP_RTI || op_r == CRF_OP_RETURN_AND_RELEASE)
					next_state = ST_POP2;
			end
			ST_POPD2:
			begin
				next_state = ST_IDLE;
				if (op_r == CRF_OP_RTI)
					fsm_st_we = 1'b1;
				else
				begin
					fsm_pc_we = 1'b1;
					next_state = ST_ADJ;
				end
			end
			ST_VEC:
			begin
				next_mem = {1'b1, 1'b0, `CRF_TRAP_BASE + {8'h00, vec_r, 1'b0}, `CRF_ZERO_WORD};
				next_state = ST_VECQ;
			end
			ST_VECD:
			begin
				fsm_pc_we = 1'b1;
				fsm_st_we = 1'b1;
				fsm_st_val = st_r;
				fsm_st_val[2:0] = `CRF_MASK_ALL;
				next_state = ST_IDLE;
			end
			ST_ADJ:
			begin
				fsm_sp_we = 1'b1;
				fsm_sp_val = (op_r == CRF_OP_LINK) ? sp_r + arg_r : sp_r - arg_r;
				next_state = ST_IDLE;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			op_r <= CRF_OP_NONE;
			arg_r <= `CRF_ZERO_WORD;
			vec_r <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (state == ST_IDLE)
			begin
				op_r <= stk.op;
				arg_r <= stk.arg;
				vec_r <= stk.vec;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			mem <= '0;
			illegal_access <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			mem <= next_mem;
			illegal_access <= next_illegal;
			busy <= next_state != ST_IDLE;
		end
	end

	a_zero_read: assert property (@(posedge clk_sys) disable iff (reset)
		rd_a_addr == `CRF_SLOT_ZERO |=> rd_a_data == `CRF_ZERO_WORD)
		else $error("slot fifteen read not zero");
	a_fetch_align: assert property (@(posedge clk_sys) disable iff (reset)
		fetch_addr == {pc, 1'b0})
		else $error("fetch address not pc word address");
	a_push_step: assert property (@(posedge clk_sys) disable iff (reset)
		state == ST_PUSH1 && !sp_r[0] |=> sp_r == $past(sp_r) + `CRF_STACK_STEP)
		else $error("push did not advance sp by two");
	a_odd_stack: assert property (@(posedge clk_sys) disable iff (reset)
		(state == ST_POP1 || state == ST_PUSH1) && sp_r[0] |=> illegal_access && !mem.req)
		else $error("odd sp access not refused");
	a_trap_mask: assert property (@(posedge clk_sys) disable iff (reset)
		state == ST_VECD |=> st_r[2:0] == `CRF_MASK_ALL ##1 status_word[2:0] == `CRF_MASK_ALL)
		else $error("trap did not raise mask level");
	a_call_target: assert property (@(posedge clk_sys) disable iff (reset)
		state == ST_PUSH1 && op_r == CRF_OP_CALL && !sp_r[0] |=> pc == $past(arg_r) && mem.we)
		else $error("call did not push and jump");
	a_ea_direct: assert property (@(posedge clk_sys) disable iff (reset)
		ea_idx == `CRF_SLOT_ZERO |=> ea == $past(ea_disp))
		else $error("zero index not direct address");
	a_byte_keep: assert property (@(posedge clk_sys) disable iff (reset)
		wr.we && wr.size == CRF_SZ_BYTE && wr.addr == 4'h5 && !alu.upd
		|=> slot[5][15:8] == $past(slot[5][15:8]) && slot[5][7:0] == $past(wr.data[7:0]))
		else $error("byte write disturbed upper byte");
endmodule : crf_top

// [sim/crf_mem_model.sv]
// memory partner answering the register file's stack cycles
`timescale 1ns/1ns
module crf_mem_model (
	input  wire logic         clk_sys,
	input  crf_pkg::crf_mem_s mem,
	output logic [15:0]       mem_rdata
);
	import crf_pkg::*;
	logic [15:0] words [0:65535];
	initial mem_rdata = 16'h0000;
	// read data stands one cycle only, then turns over
	always @(posedge clk_sys)
	begin
		if (mem.req && mem.we)
			words[mem.addr[16:1]] <= mem.wdata;
		if (mem.req && !mem.we)
			mem_rdata <= words[mem.addr[16:1]];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule : crf_mem_model

// [sim/crf_top_tb.sv]
// self-checking bench for the cpu register file
`timescale 1ns/1ns
module crf_top_tb;
	import crf_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  rd_a_addr = 4'h0;
	logic [3:0]  rd_b_addr = 4'h0;
	crf_wr_s     wr = '0;
	crf_alu_s    alu = '0;
	crf_stk_s    stk = '0;
	logic        pc_load = 1'b0;
	logic [15:0] pc_target = 16'h0000;
	logic        pc_advance = 1'b0;
	logic [3:0]  ea_idx = 4'h0;
	logic [15:0] ea_disp = 16'h0000;
	logic [15:0] mem_rdata, rd_a_data, rd_b_data, status_word, pc, ea;
	logic [16:0] fetch_addr;
	crf_mem_s    mem;
	logic        busy, illegal_access;
	logic        probe = 1'b0;
	logic        probe_seen = 1'b0;
	logic [15:0] ill_cnt = 16'h0000;
	logic [17:0] notes [$];
	logic [17:0] nt;
	logic [15:0] vals [0:15];
	int          err_total = 0;
	int          total_checks = 0;

	always #4 clk_sys = ~clk_sys;

	crf_top dut (.clk_sys(clk_sys), .reset(reset), .rd_a_addr(rd_a_addr),
		.rd_b_addr(rd_b_addr), .wr(wr), .alu(alu), .stk(stk), .pc_load(pc_load),
		.pc_target(pc_target), .pc_advance(pc_advance), .ea_idx(ea_idx),
		.ea_disp(ea_disp), .mem_rdata(mem_rdata), .rd_a_data(rd_a_data),
		.rd_b_data(rd_b_data), .status_word(status_word), .pc(pc),
		.fetch_addr(fetch_addr), .ea(ea), .mem(mem), .busy(busy),
		.illegal_access(illegal_access));

	crf_mem_model mem_m (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));

	task check(input string name, input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// expectation noted, result compared by the watcher one cycle on
	task note(input logic [1:0] sel, input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		rd_a_addr <= a;
		rd_b_addr <= a;
		ea_idx <= a;
		probe <= 1'b1;
		notes.push_back({sel, exp});
		@(posedge clk_sys);
		probe <= 1'b0;
	endtask : note

	task rd(input logic [3:0] a, input logic [15:0] exp);
		note(2'd0, a, exp);
	endtask : rd

	task pcq(input logic [15:0] exp);
		note(2'd2, 4'h0, exp);
	endtask : pcq

	task wr_slot(input logic [3:0] a, input crf_size_e sz, input logic [3:0] bi,
		input logic [15:0] d);
		@(posedge clk_sys);
		wr <= '{we:1'b1, addr:a, size:sz, bit_idx:bi, data:d};
		@(posedge clk_sys);
		wr.we <= 1'b0;
	endtask : wr_slot

	task wrw(input logic [3:0] a, input logic [15:0] d);
		wr_slot(a, CRF_SZ_WORD, 4'h0, d);
	endtask : wrw

	task alu_op(input logic wb, input crf_size_e sz, input crf_alu_e k,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] r, input logic rn);
		@(posedge clk_sys);
		alu <= '{upd:1'b1, wb:wb, dest:{3'h2, rn}, size:sz, kind:k, a:a, b:b,
			result:r, c_in:rn, v_in:1'b0, round:rn};
		@(posedge clk_sys);
		alu.upd <= 1'b0;
		alu.wb <= 1'b0;
	endtask : alu_op

	task pc_op(input logic ld, input logic [15:0] t);
		@(posedge clk_sys);
		pc_load <= ld;
		pc_advance <= ~ld;
		pc_target <= t;
		@(posedge clk_sys);
		pc_load <= 1'b0;
		pc_advance <= 1'b0;
	endtask : pc_op

	task stack_op(input crf_stack_op_e o, input logic [15:0] g, input logic [7:0] v);
		int n;
		@(posedge clk_sys);
		stk <= '{op:o, arg:g, vec:v};
		@(posedge clk_sys);
		stk.op <= CRF_OP_NONE;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (busy !== 1'b0 && n < 60);
		if (n >= 60)
		begin
			err_total++;
			test_done();
		end
		repeat (2) @(posedge clk_sys);
	endtask : stack_op

	always @(posedge clk_sys)
	begin
		probe_seen <= probe;
		if (illegal_access === 1'b1)
			ill_cnt <= ill_cnt + 16'h0001;
	end

	always @(negedge clk_sys)
	begin
		if (probe_seen && notes.size() > 0)
		begin
			nt = notes.pop_front();
			if (nt[17:16] == 2'd0)
				check("rd_a_data", {1'b0, rd_a_data}, {1'b0, nt[15:0]});
			if (nt[17:16] == 2'd0)
				check("rd_b_data", {1'b0, rd_b_data}, {1'b0, nt[15:0]});
			if (nt[17:16] == 2'd0 && rd_a_addr == 4'he)
				check("status_word", {1'b0, status_word}, {1'b0, nt[15:0]});
			if (nt[17:16] == 2'd1)
				check("ea", {1'b0, ea}, {1'b0, nt[15:0]});
			if (nt[17:16] == 2'd2)
				check("pc", {1'b0, pc}, {1'b0, nt[15:0]});
			if (nt[17:16] == 2'd2)
				check("fetch_addr", fetch_addr, {nt[15:0], 1'b0});
			if (nt[17:16] == 2'd3)
				check("illegal_count", {1'b0, ill_cnt}, {1'b0, nt[15:0]});
		end
	end

	initial
	begin
		void'($urandom(80));
		mem_m.words[16'h4003] = 16'h5a5a;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		pcq(16'h0000);
		for (int i = 0; i < 16; i++)
		begin
			vals[i] = 16'($urandom);
			wrw(4'(i), vals[i]);
		end
		for (int i = 0; i < 16; i++)
			rd(4'(i), (i == 15) ? 16'h0000 : (i == 14) ? vals[i] & 16'hf007 : vals[i]);
		ea_disp <= 16'h0300;
		note(2'd1, 4'h5, 16'h0300 + vals[5]);
		note(2'd1, 4'hf, 16'h0300);
		wrw(4'h6, 16'h0000);
		wr_slot(4'h6, CRF_SZ_BIT, 4'h9, 16'h0001);
		rd(4'h6, 16'h0200);
		wr_slot(4'h5, CRF_SZ_BYTE, 4'h0, 16'h5a3c);
		rd(4'h5, {vals[5][15:8], 8'h3c});
		pc_op(1'b1, 16'h0abc);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		pcq(16'h0000);
		rd(4'h3, vals[3]);
		wrw(4'he, 16'hffff);
		rd(4'he, 16'hf007);
		alu_op(1'b0, CRF_SZ_BYTE, CRF_ALU_ADD, 32'h80, 32'h80, 32'h0, 1'b0);
		rd(4'he, 16'hb007);
		alu_op(1'b0, CRF_SZ_WORD, CRF_ALU_SUB, 32'h0, 32'h1, 32'h0, 1'b0);
		rd(4'he, 16'hc007);
		alu_op(1'b1, CRF_SZ_LONG, CRF_ALU_ADD, 32'h7fffffff, 32'h1, 32'h0, 1'b0);
		rd(4'he, 16'h5007);
		rd(4'h4, 16'h0000);
		rd(4'h1, 16'h8000);
		alu_op(1'b1, CRF_SZ_LONG, CRF_ALU_PASS, 32'h0, 32'h0, 32'hfffffffe, 1'b1);
		rd(4'h5, 16'hffff);
		rd(4'h1, 16'hffff);
		alu_op(1'b0, CRF_SZ_BIT, CRF_ALU_PASS, 32'h0, 32'h0, 32'h1, 1'b0);
		rd(4'he, 16'h8007);
		wrw(4'hd, 16'h0100);
		wrw(4'h0, 16'h0200);
		wrw(4'he, 16'h1234);
		pc_op(1'b1, 16'h1234);
		pc_op(1'b0, 16'h0000);
		pcq(16'h1235);
		stack_op(CRF_OP_CALL, 16'h4000, 8'h00);
		pcq(16'h4000);
		rd(4'hd, 16'h0102);
		stack_op(CRF_OP_RTS, 16'h0000, 8'h00);
		pcq(16'h1235);
		rd(4'hd, 16'h0100);
		stack_op(CRF_OP_LINK, 16'h0010, 8'h00);
		rd(4'h0, 16'h0102);
		rd(4'hd, 16'h0112);
		stack_op(CRF_OP_UNLINK, 16'h0000, 8'h00);
		rd(4'hd, 16'h0100);
		rd(4'h0, 16'h0200);
		stack_op(CRF_OP_TRAP, 16'h0000, 8'h03);
		pcq(16'h5a5a);
		rd(4'he, 16'h1007);
		rd(4'hd, 16'h0104);
		stack_op(CRF_OP_RTI, 16'h0000, 8'h00);
		pcq(16'h1235);
		rd(4'he, 16'h1004);
		rd(4'hd, 16'h0100);
		stack_op(CRF_OP_CALL, 16'h4000, 8'h00);
		stack_op(CRF_OP_LINK, 16'h0010, 8'h00);
		stack_op(CRF_OP_RETURN_AND_RELEASE, 16'h0004, 8'h00);
		pcq(16'h1235);
		rd(4'h0, 16'h0200);
		rd(4'hd, 16'h00fc);
		wrw(4'hd, 16'h0101);
		stack_op(CRF_OP_CALL, 16'h4000, 8'h00);
		note(2'd3, 4'h0, 16'h0001);
		pcq(16'h1235);
		rd(4'hd, 16'h0101);
		repeat (4) @(posedge clk_sys);
		check("notes_left", 17'(notes.size()), 17'h00000);
		test_done();
	end
endmodule : crf_top_tb
